// ===== scf_regs_bank.sv
// Configuration register bank for the clamp, formatter and colour converter of the sensor path.
// Assumes an Avalon-MM master on ref_clk_i and consumers of the field outputs on the same clock.
//
// Behaviour
// - Five-bit per-colour horizontal clamp window count, 0 to 31.
// - Thirteen-bit horizontal start pixel of the horizontal clamp windows.
// - Thirteen-bit vertical start line of the horizontal clamp windows.
// - Twelve-bit unsigned preset loaded into the running clamp value.
// - Eight-bit line average weight in bits 15 to 8.
// - Two-bit previous-line initial value select; code three is reserved.
// - Three-bit power-of-two width of the black region in bits 2 to 0.
// - Thirteen-bit start column of the black region.
// - Thirteen-bit start row of the black region.
// - Thirteen-bit count of valid black region rows.
// - Thirteen-bit first formatter pixel and first formatter line.
// - Formatter pixels per input line equal programmed value plus one.
// - Formatter input lines equal fifteen-bit programmed value plus one.
// - Output line length programmed; above 4480 is not allowed, but larger values are stored as written and flagged in status bit 0.
// - Thirteen-bit output line sync interval; zero when merging lines.
// - Colour converter enable at bit zero; zero keeps it off.

`timescale 1ns/100ps
`include "scf_regs.svh"

module scf_regs_bank
    import scf_pkg::*;
(
    // Clock and reset.
    input  wire logic                   ref_clk_i,
    input  wire logic                   rstn_i,
    // Avalon-MM slave.
    input  wire logic [`SCF_ADDR_W-1:0] address_i,
    input  wire logic                   read_i,
    input  wire logic                   write_i,
    input  wire logic [31:0]            writedata_i,
    input  wire logic [3:0]             byteenable_i,
    output logic      [31:0]            readdata_o,
    output logic      [1:0]             response_o,
    output logic                        waitrequest_o,
    // Horizontal clamp settings.
    output logic      [4:0]             hclamp_windows_per_colour_o,
    output logic                        hclamp_base_window_sel_o,
    output logic      [12:0]            hclamp_start_col_o,
    output logic      [12:0]            hclamp_start_row_o,
    // Vertical clamp settings.
    output logic      [11:0]            clamp_preset_value_o,
    output logic      [7:0]             line_average_weight_o,
    output logic      [1:0]             prev_line_init_select_o,
    output logic      [2:0]             black_region_width_exp_o,
    output logic      [12:0]            black_region_start_col_o,
    output logic      [12:0]            black_region_start_row_o,
    output logic      [12:0]            black_region_rows_o,
    // Formatter settings.
    output logic      [12:0]            fmt_first_pixel_o,
    output logic      [12:0]            fmt_pixels_minus_one_o,
    output logic      [12:0]            fmt_first_line_o,
    output logic      [14:0]            fmt_lines_minus_one_o,
    output logic      [12:0]            fmt_out_line_len_o,
    output logic      [12:0]            fmt_out_line_interval_o,
    // Colour converter control.
    output logic                        color_convert_on_o
);

    // Byte-lane merge of write data over the old register contents.
    function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Bus handshake and read decode.
    logic                 wait_ff;
    logic                 wr_go;
    logic [31:0]          nxt_rdata;
    logic                 nxt_hit;

    // Horizontal clamp fields.
    logic [4:0]           wpc_ff;
    logic                 bws_ff;
    scf_pos_t             hcol_ff;
    scf_pos_t             hrow_ff;

    // Vertical clamp fields.
    logic [11:0]          preset_ff;
    logic [7:0]           coef_ff;
    scf_init_sel_e        init_ff;
    logic [2:0]           obw_ff;
    scf_pos_t             obcol_ff;
    scf_pos_t             obrow_ff;
    scf_pos_t             obrows_ff;

    // Formatter fields.
    scf_pos_t             pix0_ff;
    scf_pos_t             npix_ff;
    scf_pos_t             line0_ff;
    logic [14:0]          nline_ff;
    scf_pos_t             olen_ff;
    scf_pos_t             oint_ff;

    // Converter enable and status flags.
    logic                 csc_ff;
    logic                 len_over_ff;
    logic                 init_rsvd_ff;
    logic                 merge_mode_ff;

    // Write data merged over the addressed register.
    logic [31:0]          wmerged;
    logic [31:0]          old_word;

    // Handshake: a request is answered on the cycle after it is first seen.
    assign wr_go = write_i && !wait_ff;

    // Wait state; drops for exactly one cycle per request.
    // Read data are registered, so every request needs one wait cycle.
    // Back-to-back requests therefore take two cycles each.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_ff <= 1'b1;
        end else if ((read_i || write_i) && wait_ff) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    // Read decode of every register; reserved bits fill with zero.
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_hit   = 1'b1;
        if (address_i == `SCF_OFS_HWIN_CFG) begin
            nxt_rdata[`SCF_WPC_LSB +: 5] = wpc_ff;
            nxt_rdata[`SCF_BWS_BIT]      = bws_ff;
        end else if (address_i == `SCF_OFS_HWIN_COL) begin
            nxt_rdata[12:0] = hcol_ff;
        end else if (address_i == `SCF_OFS_HWIN_ROW) begin
            nxt_rdata[12:0] = hrow_ff;
        end else if (address_i == `SCF_OFS_PRESET) begin
            nxt_rdata[11:0] = preset_ff;
        end else if (address_i == `SCF_OFS_VCFG) begin
            nxt_rdata[`SCF_COEF_LSB +: 8] = coef_ff;
            nxt_rdata[`SCF_INIT_LSB +: 2] = init_ff;
            nxt_rdata[`SCF_OBW_LSB +: 3]  = obw_ff;
        end else if (address_i == `SCF_OFS_OB_COL) begin
            nxt_rdata[12:0] = obcol_ff;
        end else if (address_i == `SCF_OFS_OB_ROW) begin
            nxt_rdata[12:0] = obrow_ff;
        end else if (address_i == `SCF_OFS_OB_ROWS) begin
            nxt_rdata[12:0] = obrows_ff;
        end else if (address_i == `SCF_OFS_FMT_PIX0) begin
            nxt_rdata[12:0] = pix0_ff;
        end else if (address_i == `SCF_OFS_FMT_NPIX) begin
            nxt_rdata[12:0] = npix_ff;
        end else if (address_i == `SCF_OFS_FMT_LINE0) begin
            nxt_rdata[12:0] = line0_ff;
        end else if (address_i == `SCF_OFS_FMT_NLINE) begin
            nxt_rdata[14:0] = nline_ff;
        end else if (address_i == `SCF_OFS_FMT_OLEN) begin
            nxt_rdata[12:0] = olen_ff;
        end else if (address_i == `SCF_OFS_FMT_OINT) begin
            nxt_rdata[12:0] = oint_ff;
        end else if (address_i == `SCF_OFS_CSC_CTL) begin
            nxt_rdata[`SCF_CSC_BIT] = csc_ff;
        end else if (address_i == `SCF_OFS_STATUS) begin
            nxt_rdata[0] = len_over_ff;
            nxt_rdata[1] = init_rsvd_ff;
            nxt_rdata[2] = merge_mode_ff;
        end else begin
            nxt_hit = 1'b0;
        end
    end

    // Read data and response are captured as the wait state drops.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            readdata_o <= 32'h0000_0000;
            response_o <= `SCF_RESP_OKAY;
        end else if ((read_i || write_i) && wait_ff) begin
            readdata_o <= read_i ? nxt_rdata : 32'h0000_0000;
            response_o <= nxt_hit ? `SCF_RESP_OKAY : `SCF_RESP_SLVERR;
        end
    end

    // The stored field of the addressed register, for lane merging.
    assign old_word = nxt_rdata;
    assign wmerged  = be_merge(old_word, writedata_i, byteenable_i);

    // Horizontal clamp window configuration.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wpc_ff <= `SCF_RST_5;
            bws_ff <= 1'b0;
        end else if (wr_go && address_i == `SCF_OFS_HWIN_CFG) begin
            wpc_ff <= wmerged[`SCF_WPC_LSB +: 5];
            bws_ff <= wmerged[`SCF_BWS_BIT];
        end
    end

    // Horizontal clamp window start column.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hcol_ff <= `SCF_RST_13;
        end else if (wr_go && address_i == `SCF_OFS_HWIN_COL) begin
            hcol_ff <= wmerged[12:0];
        end
    end

    // Horizontal clamp window start row.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hrow_ff <= `SCF_RST_13;
        end else if (wr_go && address_i == `SCF_OFS_HWIN_ROW) begin
            hrow_ff <= wmerged[12:0];
        end
    end

    // Clamp preset value; reserved upper bits are dropped.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            preset_ff <= `SCF_RST_12;
        end else if (wr_go && address_i == `SCF_OFS_PRESET) begin
            preset_ff <= wmerged[11:0];
        end
    end

    // Vertical clamp configuration fields.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            coef_ff <= `SCF_RST_8;
            init_ff <= SCF_INIT_BASE;
            obw_ff  <= `SCF_RST_3;
        end else if (wr_go && address_i == `SCF_OFS_VCFG) begin
            coef_ff <= wmerged[`SCF_COEF_LSB +: 8];
            init_ff <= scf_init_sel_e'(wmerged[`SCF_INIT_LSB +: 2]);
            obw_ff  <= wmerged[`SCF_OBW_LSB +: 3];
        end
    end

    // Black region start column.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            obcol_ff <= `SCF_RST_13;
        end else if (wr_go && address_i == `SCF_OFS_OB_COL) begin
            obcol_ff <= wmerged[12:0];
        end
    end

    // Black region start row.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            obrow_ff <= `SCF_RST_13;
        end else if (wr_go && address_i == `SCF_OFS_OB_ROW) begin
            obrow_ff <= wmerged[12:0];
        end
    end

    // Black region valid row count.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            obrows_ff <= `SCF_RST_13;
        end else if (wr_go && address_i == `SCF_OFS_OB_ROWS) begin
            obrows_ff <= wmerged[12:0];
        end
    end

    // Formatter first input pixel.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pix0_ff <= `SCF_RST_13;
        end else if (wr_go && address_i == `SCF_OFS_FMT_PIX0) begin
            pix0_ff <= wmerged[12:0];
        end
    end

    // Formatter pixels per line, stored as count minus one.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            npix_ff <= `SCF_RST_13;
        end else if (wr_go && address_i == `SCF_OFS_FMT_NPIX) begin
            npix_ff <= wmerged[12:0];
        end
    end

    // Formatter first input line.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            line0_ff <= `SCF_RST_13;
        end else if (wr_go && address_i == `SCF_OFS_FMT_LINE0) begin
            line0_ff <= wmerged[12:0];
        end
    end

    // Formatter input line count, stored as count minus one.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nline_ff <= `SCF_RST_15;
        end else if (wr_go && address_i == `SCF_OFS_FMT_NLINE) begin
            nline_ff <= wmerged[14:0];
        end
    end

    // Formatter output line length; stored as written, flagged if too long.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            olen_ff <= `SCF_RST_13;
        end else if (wr_go && address_i == `SCF_OFS_FMT_OLEN) begin
            olen_ff <= wmerged[12:0];
        end
    end

    // Formatter output line sync interval.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oint_ff <= `SCF_RST_13;
        end else if (wr_go && address_i == `SCF_OFS_FMT_OINT) begin
            oint_ff <= wmerged[12:0];
        end
    end

    // Colour converter on or off.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            csc_ff <= 1'b0;
        end else if (wr_go && address_i == `SCF_OFS_CSC_CTL) begin
            csc_ff <= wmerged[`SCF_CSC_BIT];
        end
    end

    // Status: checks of the programmed set-up, refreshed every cycle.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            len_over_ff   <= 1'b0;
            init_rsvd_ff  <= 1'b0;
            merge_mode_ff <= 1'b0;
        end else begin
            len_over_ff   <= (olen_ff > `SCF_OUT_LEN_MAX);
            init_rsvd_ff  <= (init_ff == SCF_INIT_RSVD);
            merge_mode_ff <= (oint_ff == `SCF_RST_13);
        end
    end

    // The wait state drives the bus handshake directly.
    assign waitrequest_o               = wait_ff;

    // Field outputs come straight from their flip-flops.
    assign hclamp_windows_per_colour_o = wpc_ff;
    assign hclamp_base_window_sel_o    = bws_ff;
    assign hclamp_start_col_o          = hcol_ff;
    assign hclamp_start_row_o          = hrow_ff;
    assign clamp_preset_value_o        = preset_ff;
    assign line_average_weight_o       = coef_ff;
    assign prev_line_init_select_o     = init_ff;
    assign black_region_width_exp_o    = obw_ff;
    assign black_region_start_col_o    = obcol_ff;
    assign black_region_start_row_o    = obrow_ff;
    assign black_region_rows_o         = obrows_ff;
    assign fmt_first_pixel_o           = pix0_ff;
    assign fmt_pixels_minus_one_o      = npix_ff;
    assign fmt_first_line_o            = line0_ff;
    assign fmt_lines_minus_one_o       = nline_ff;
    assign fmt_out_line_len_o          = olen_ff;
    assign fmt_out_line_interval_o     = oint_ff;
    assign color_convert_on_o          = csc_ff;

endmodule

// ===== scf_regs.svh
// Register offsets, field widths and reset values of the sensor clamp and formatter bank.
// Assumes byte addresses on a 32-bit bus with every register on an aligned word.
`ifndef SCF_REGS_SVH
`define SCF_REGS_SVH

`define SCF_ADDR_W          6
`define SCF_OFS_HWIN_CFG    6'h00
`define SCF_OFS_HWIN_COL    6'h04
`define SCF_OFS_HWIN_ROW    6'h08
`define SCF_OFS_PRESET      6'h0C
`define SCF_OFS_VCFG        6'h10
`define SCF_OFS_OB_COL      6'h14
`define SCF_OFS_OB_ROW      6'h18
`define SCF_OFS_OB_ROWS     6'h1C
`define SCF_OFS_FMT_PIX0    6'h20
`define SCF_OFS_FMT_NPIX    6'h24
`define SCF_OFS_FMT_LINE0   6'h28
`define SCF_OFS_FMT_NLINE   6'h2C
`define SCF_OFS_FMT_OLEN    6'h30
`define SCF_OFS_FMT_OINT    6'h34
`define SCF_OFS_CSC_CTL     6'h38
`define SCF_OFS_STATUS      6'h3C

`define SCF_WPC_LSB         0
`define SCF_BWS_BIT         5
`define SCF_COEF_LSB        8
`define SCF_INIT_LSB        4
`define SCF_OBW_LSB         0
`define SCF_CSC_BIT         0

`define SCF_RST_5           5'h00
`define SCF_RST_13          13'h0000
`define SCF_RST_12          12'h000
`define SCF_RST_15          15'h0000
`define SCF_RST_8           8'h00
`define SCF_RST_3           3'h0
`define SCF_OUT_LEN_MAX     13'h1180
`define SCF_RESP_OKAY       2'h0
`define SCF_RESP_SLVERR     2'h2

`endif

// ===== scf_pkg.sv
// Types shared by the sensor clamp and formatter register bank.
// Assumes the offsets and reset values come from scf_regs.svh.
package scf_pkg;

    // Choice of the previous-line clamp value at frame start.
    typedef enum logic [1:0] {
        SCF_INIT_BASE,
        SCF_INIT_PRESET,
        SCF_INIT_KEEP,
        SCF_INIT_RSVD
    } scf_init_sel_e;

    typedef logic [12:0] scf_pos_t;

endpackage

// ===== scf_regs_bank_sva.sv
// Concurrent checks of the clamp and formatter register bank, seen at its ports.
// Assumes it is bound to scf_regs_bank and that requests follow the bus handshake.
`timescale 1ns/100ps
`include "scf_regs.svh"

module scf_regs_bank_sva (
    // Clock, reset and bus.
    input  wire logic                   ref_clk_i,
    input  wire logic                   rstn_i,
    input  wire logic [`SCF_ADDR_W-1:0] address_i,
    input  wire logic                   read_i,
    input  wire logic                   write_i,
    input  wire logic [31:0]            writedata_i,
    input  wire logic [3:0]             byteenable_i,
    input  wire logic [31:0]            readdata_o,
    input  wire logic [1:0]             response_o,
    input  wire logic                   waitrequest_o,
    // Watched fields.
    input  wire logic [4:0]             hclamp_windows_per_colour_o,
    input  wire logic                   hclamp_base_window_sel_o,
    input  wire logic [1:0]             prev_line_init_select_o,
    input  wire logic [14:0]            fmt_lines_minus_one_o,
    input  wire logic [12:0]            fmt_out_line_len_o,
    input  wire logic                   color_convert_on_o
);
    // A write lands at the edge where waitrequest is low; a read is taken while it is high.
    logic wr_acc;
    logic rd_req;
    assign wr_acc = write_i && !waitrequest_o;
    assign rd_req = read_i && waitrequest_o;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    AST_CSC_WRITE: assert property (
        wr_acc && address_i == `SCF_OFS_CSC_CTL && byteenable_i[0]
        |=> color_convert_on_o == $past(writedata_i[0]))
        else $error("Converter enable does not follow the write.");
    AST_WPC_WRITE: assert property (
        wr_acc && address_i == `SCF_OFS_HWIN_CFG && byteenable_i[0]
        |=> {hclamp_base_window_sel_o, hclamp_windows_per_colour_o} == $past(writedata_i[5:0]))
        else $error("Window count or base select does not follow the write.");
    AST_NLINE_WRITE: assert property (
        wr_acc && address_i == `SCF_OFS_FMT_NLINE && byteenable_i[1:0] == 2'h3
        |=> fmt_lines_minus_one_o == $past(writedata_i[14:0]))
        else $error("Line count does not hold all fifteen written bits.");
    AST_OLEN_HOLD: assert property (
        !(wr_acc && address_i == `SCF_OFS_FMT_OLEN) |=> $stable(fmt_out_line_len_o))
        else $error("Output line length changed without a write.");
    AST_INIT_HOLD: assert property (
        !(wr_acc && address_i == `SCF_OFS_VCFG) |=> $stable(prev_line_init_select_o))
        else $error("Init select changed without a write.");
    AST_OLEN_READ: assert property (
        rd_req && address_i == `SCF_OFS_FMT_OLEN |=> !waitrequest_o
        && readdata_o == {19'h0_0000, fmt_out_line_len_o} && response_o == `SCF_RESP_OKAY)
        else $error("Output line length read back wrong.");
    AST_CSC_READ: assert property (
        rd_req && address_i == `SCF_OFS_CSC_CTL
        |=> !waitrequest_o && readdata_o == {31'h0000_0000, color_convert_on_o})
        else $error("Converter control read back wrong.");
    AST_UNMAPPED: assert property (
        (read_i || write_i) && waitrequest_o && address_i[1:0] != 2'h0 |=> !waitrequest_o
        && response_o == `SCF_RESP_SLVERR && readdata_o == 32'h0000_0000)
        else $error("Unmapped access not refused.");

    // Main scenarios reached.
    COV_CSC_WRITE: cover property (wr_acc && address_i == `SCF_OFS_CSC_CTL);
    COV_OLEN_READ: cover property (rd_req && address_i == `SCF_OFS_FMT_OLEN);
    COV_REFUSED: cover property (!waitrequest_o && response_o == `SCF_RESP_SLVERR);
endmodule

// ===== scf_regs_bank_tb.sv
// Self-checking bench of the clamp and formatter register bank over Avalon-MM.
// Assumes one bus transfer answers after one wait cycle and fields reset to zero.
`timescale 1ns/100ps
`include "scf_regs.svh"

module testbench;
    logic                   ref_clk_i    = 1'b0;
    logic                   rstn_i       = 1'b0;
    logic [`SCF_ADDR_W-1:0] address_i    = 6'h00;
    logic                   read_i       = 1'b0;
    logic                   write_i      = 1'b0;
    logic [31:0]            writedata_i  = 32'h0000_0000;
    logic [3:0]             byteenable_i = 4'h0;
    logic [31:0]            readdata_o;
    logic [1:0]             response_o;
    logic                   waitrequest_o;
    logic [4:0]             hwc;
    logic                   hbs;
    logic [12:0]            hcol, hrow, bcol, brow, brows, fpix, fnpix, fline, folen, foint;
    logic [11:0]            preset;
    logic [7:0]             weight;
    logic [1:0]             isel;
    logic [2:0]             wexp;
    logic [14:0]            fnline;
    logic                   csc;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    int                     error_cnt    = 0;
    int                     total_checks = 0;
    logic [31:0]            mask [15]    = '{32'h0000_003F, 32'h0000_1FFF, 32'h0000_1FFF,
        32'h0000_0FFF, 32'h0000_FF37, 32'h0000_1FFF, 32'h0000_1FFF, 32'h0000_1FFF,
        32'h0000_1FFF, 32'h0000_1FFF, 32'h0000_1FFF, 32'h0000_7FFF, 32'h0000_1FFF,
        32'h0000_1FFF, 32'h0000_0001};

    // Clock of 25 ns.
    always #12.5 ref_clk_i = ~ref_clk_i;

    scf_regs_bank u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o), .response_o(response_o),
        .waitrequest_o(waitrequest_o), .hclamp_windows_per_colour_o(hwc),
        .hclamp_base_window_sel_o(hbs), .hclamp_start_col_o(hcol), .hclamp_start_row_o(hrow),
        .clamp_preset_value_o(preset), .line_average_weight_o(weight),
        .prev_line_init_select_o(isel), .black_region_width_exp_o(wexp),
        .black_region_start_col_o(bcol), .black_region_start_row_o(brow),
        .black_region_rows_o(brows), .fmt_first_pixel_o(fpix), .fmt_pixels_minus_one_o(fnpix),
        .fmt_first_line_o(fline), .fmt_lines_minus_one_o(fnline), .fmt_out_line_len_o(folen),
        .fmt_out_line_interval_o(foint), .color_convert_on_o(csc));

    // Field outputs laid out as the register word at index i.
    function automatic logic [31:0] view(input int i);
        logic [31:0] v [15];
        v = '{{26'h0, hbs, hwc}, {19'h0, hcol}, {19'h0, hrow}, {20'h0, preset},
            {16'h0, weight, 2'h0, isel, 1'h0, wexp}, {19'h0, bcol}, {19'h0, brow},
            {19'h0, brows}, {19'h0, fpix}, {19'h0, fnpix}, {19'h0, fline}, {17'h0, fnline},
            {19'h0, folen}, {19'h0, foint}, {31'h0, csc}};
        return v[i];
    endfunction

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One transfer; the request stays up so the next one can follow back to back.
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                        input logic [3:0] be);
        int n;
        n = 0;
        read_i <= !wr;
        write_i <= wr;
        address_i <= a;
        writedata_i <= d;
        byteenable_i <= be;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 40);
        if (waitrequest_o !== 1'b0) begin
            chk("waitrequest", 32'h0, {31'h0, waitrequest_o});
            end_sim();
        end else begin
            rdata = readdata_o;
            rresp = response_o;
        end
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0000_0000, 4'h0);
        chk(what, exp, rdata);
    endtask

    task automatic idle();
        read_i <= 1'b0;
        write_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic test_reset();
        for (int i = 0; i < 15; i++) rd_chk(6'(i * 4), 32'h0, "reset read");
        rd_chk(`SCF_OFS_STATUS, 32'h0000_0004, "reset status");
        idle();
        for (int i = 0; i < 15; i++) chk("reset port", 32'h0, view(i));
        $display("test_reset done");
    endtask

    // Writes every writable register back to back, then reads back and checks the ports.
    task automatic test_fields(input logic [31:0] base);
        for (int i = 0; i < 15; i++) xfer(1'b1, 6'(i * 4), (base ^ i) & mask[i], 4'hF);
        for (int i = 0; i < 15; i++) begin
            rd_chk(6'(i * 4), (base ^ i) & mask[i], "field read");
            chk("field resp", 32'h0, {30'h0, rresp});
        end
        idle();
        for (int i = 0; i < 15; i++) chk("field port", (base ^ i) & mask[i], view(i));
        $display("test_fields done");
    endtask

    task automatic test_access();
        xfer(1'b1, `SCF_OFS_FMT_NLINE, 32'h0000_7FFF, 4'hF);
        xfer(1'b1, `SCF_OFS_FMT_NLINE, 32'h0000_0012, 4'h1);
        xfer(1'b1, `SCF_OFS_FMT_NLINE, 32'h0000_3400, 4'h2);
        rd_chk(`SCF_OFS_FMT_NLINE, 32'h0000_3412, "lane merge");
        xfer(1'b1, 6'h3A, 32'hFFFF_FFFF, 4'hF);
        chk("unmapped write resp", 32'h2, {30'h0, rresp});
        xfer(1'b0, 6'h01, 32'h0, 4'h0);
        chk("unmapped read", 32'h0000_0002, {rdata[29:0], rresp});
        xfer(1'b1, `SCF_OFS_STATUS, 32'h0000_0000, 4'hF);
        chk("status write resp", 32'h0, {30'h0, rresp});
        rd_chk(`SCF_OFS_CSC_CTL, 32'h0000_0000, "after refusals");
        idle();
        $display("test_access done");
    endtask

    task automatic test_limits();
        xfer(1'b1, `SCF_OFS_FMT_OINT, 32'h0000_0001, 4'hF);
        xfer(1'b1, `SCF_OFS_FMT_OLEN, 32'h0000_1180, 4'hF);
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, `SCF_OFS_VCFG, 32'(c) << 4, 4'hF);
            idle();
            rd_chk(`SCF_OFS_VCFG, 32'(c) << 4, "init select");
            chk("init port", 32'(c), {30'h0, isel});
            rd_chk(`SCF_OFS_STATUS, (c == 3) ? 32'h2 : 32'h0, "status select");
        end
        xfer(1'b1, `SCF_OFS_FMT_OLEN, 32'h0000_1181, 4'hF);
        idle();
        rd_chk(`SCF_OFS_STATUS, 32'h0000_0003, "status long line");
        rd_chk(`SCF_OFS_FMT_OLEN, 32'h0000_1181, "long line kept");
        xfer(1'b1, `SCF_OFS_FMT_OINT, 32'h0000_0000, 4'hF);
        idle();
        rd_chk(`SCF_OFS_STATUS, 32'h0000_0007, "status merge");
        idle();
        $display("test_limits done");
    endtask

    task automatic test_midreset();
        rstn_i <= 1'b0;
        @(posedge ref_clk_i);
        for (int i = 0; i < 15; i++) chk("mid reset port", 32'h0, view(i));
        repeat (12) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rd_chk(`SCF_OFS_HWIN_CFG, 32'h0, "after mid reset");
        idle();
        $display("test_midreset done");
    endtask

    // Reset for 12 cycles, then the scenarios in turn.
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        test_reset();
        test_fields(32'hFFFF_FFFF);
        test_fields(32'hA5A5_5A5A);
        test_access();
        test_limits();
        test_midreset();
        end_sim();
    end
endmodule

bind scf_regs_bank scf_regs_bank_sva u_sva (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .response_o(response_o),
    .waitrequest_o(waitrequest_o), .hclamp_windows_per_colour_o(hclamp_windows_per_colour_o),
    .hclamp_base_window_sel_o(hclamp_base_window_sel_o),
    .prev_line_init_select_o(prev_line_init_select_o),
    .fmt_lines_minus_one_o(fmt_lines_minus_one_o), .fmt_out_line_len_o(fmt_out_line_len_o),
    .color_convert_on_o(color_convert_on_o));
